// [bdm_pkg.sv]
// Package of constants and types for the banked data memory addressing block
//**************************************************************
// Function
// - Indirect port access goes to pointer's location
// - Port zero bank 0; port one selected bank
// - Pointer at indirect port reads 00H, ignores write
// - Direct accesses always land in bank 0
// - Bit 5 program bank, bits 2:0 data bank
// - Reset clears bank except watchdog power-down reset
// - Special-function region ignores bank selection
// - Largest variant decodes codes 000-111 as banks 0-7
// - Program bank bit picks lower or upper 8K
// - Unimplemented bank-select bits read as zero
// - Pointers are ordinary read/write registers
//**************************************************************
package bdm_pkg;
    localparam int BDM_AW = 8;
    localparam int BDM_DW = 8;
    localparam int BDM_BANKS = 8;
    localparam int BDM_BW = 3;
    localparam int BDM_PAW = 14;
    // Register offsets in the special-function area
    localparam logic [7:0] BDM_OFS_PORT0 = 8'h00;
    localparam logic [7:0] BDM_OFS_PTR0 = 8'h01;
    localparam logic [7:0] BDM_OFS_PORT1 = 8'h02;
    localparam logic [7:0] BDM_OFS_PTR1 = 8'h03;
    localparam logic [7:0] BDM_OFS_BANK = 8'h04;
    // First general-purpose address; below it is the special-function area
    localparam logic [7:0] BDM_GP_BASE = 8'h80;
    localparam logic [7:0] BDM_ZERO = 8'h00;
    // Bank-select field positions and reset value
    localparam int BDM_PB_BIT = 5;
    localparam logic [7:0] BDM_BANK_RST = 8'h00;
    // Variant codes, named by the number of data banks they offer
    localparam logic [2:0] BDM_VAR_BANK8 = 3'h3;
    localparam logic [2:0] BDM_VAR_BANK6 = 3'h2;
    localparam logic [2:0] BDM_VAR_BANK4 = 3'h1;
    localparam logic [2:0] BDM_VAR_BANK2 = 3'h0;
    // Program-memory bank base addresses
    localparam logic [13:0] BDM_PM_BASE0 = 14'h0000;
    localparam logic [13:0] BDM_PM_BASE1 = 14'h2000;

    // One access from the core datapath
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bdm_req_t;

    // Physical memory access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bdm_mem_t;
endpackage

// [bdm_ram.sv]
// Banked general-purpose data memory with registered read data
`timescale 1ns/10ps
module bdm_ram
    import bdm_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Access
    input wire bdm_mem_t mem,
    output logic [7:0] rdata
);
    logic [7:0] store [0:BDM_BANKS*128-1];
    logic [9:0] idx;

    // Bank and low seven address bits form the word index
    always_comb begin
        idx = {mem.bank, mem.addr[6:0]};
    end

    // No reset: contents are undefined at power-up, like the real RAM
    always_ff @(posedge ref_clk) begin
        if (mem.wr) begin
            store[idx] <= mem.wdata;
        end
        if (mem.rd) begin
            rdata <= store[idx];
        end
    end
endmodule

// [bdm_top.sv]
// Data-memory addressing: indirect ports, pointers and bank select
`timescale 1ns/10ps
module bdm_top
    import bdm_pkg::*;
#(
    parameter logic [2:0] VARIANT = BDM_VAR_BANK8
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Reset cause: watchdog time-out while powered down
    input wire logic watchdog_pd_reset,
    // Core request
    input wire bdm_req_t req,
    // Core answer
    output logic rd_valid_r,
    output logic [7:0] rdata_r,
    // Program bank base for the fetch unit
    output logic [13:0] prog_base_r,
    // Current bank-select view
    output logic [7:0] bank_select_r
);
    //**************************************************************
    // Register state
    //**************************************************************
    logic [7:0] ptr0_r, ptr0_nxt;
    logic [7:0] ptr1_r, ptr1_nxt;
    logic [2:0] dbank_r, dbank_nxt;
    logic pbank_r, pbank_nxt;
    logic [13:0] prog_base_nxt;
    logic [7:0] bank_select_nxt;
    logic rd_valid_nxt;
    logic [7:0] reg_rdata_r, reg_rdata_nxt;
    logic ram_sel_r, ram_sel_nxt;
    bdm_mem_t mem;
    logic [7:0] ram_rdata;
    logic [7:0] eff_addr;
    logic [2:0] eff_bank;
    logic use_ram;
    logic port_hit;

    // Mask of data bank bits implemented in this variant
    function automatic logic [2:0] bank_mask(input logic [2:0] v);
        case (v)
            BDM_VAR_BANK2: bank_mask = 3'h1;
            BDM_VAR_BANK4: bank_mask = 3'h3;
            default: bank_mask = 3'h7;
        endcase
    endfunction

    // True when the address names one of the two indirect ports
    function automatic logic is_port(input logic [7:0] a);
        is_port = (a == BDM_OFS_PORT0) || (a == BDM_OFS_PORT1);
    endfunction

    //**************************************************************
    // Address resolution
    //**************************************************************
    // Indirect ports redirect through the pointers; direct goes to bank 0
    always_comb begin
        eff_addr = req.addr;
        eff_bank = '0;
        port_hit = 1'b0;
        if (req.addr == BDM_OFS_PORT0) begin
            eff_addr = ptr0_r;
            eff_bank = '0;
            port_hit = 1'b1;
        end else if (req.addr == BDM_OFS_PORT1) begin
            eff_addr = ptr1_r;
            eff_bank = dbank_r;
            port_hit = 1'b1;
        end
        // Special-function area is shared by all banks
        if (eff_addr < BDM_GP_BASE) begin
            eff_bank = '0;
        end
        use_ram = (eff_addr >= BDM_GP_BASE);
        mem.rd = req.rd && use_ram;
        mem.wr = req.wr && use_ram;
        mem.bank = eff_bank;
        mem.addr = eff_addr;
        mem.wdata = req.wdata;
    end

    bdm_ram u_ram (
        .ref_clk(ref_clk),
        .mem(mem),
        .rdata(ram_rdata)
    );

    //**************************************************************
    // Special-function registers
    //**************************************************************
    // Pointer and bank writes; a pointer at a port makes writes vanish
    always_comb begin
        ptr0_nxt = ptr0_r;
        ptr1_nxt = ptr1_r;
        dbank_nxt = dbank_r;
        pbank_nxt = pbank_r;
        reg_rdata_nxt = BDM_ZERO;
        ram_sel_nxt = req.rd && use_ram;
        rd_valid_nxt = req.rd;
        if (req.wr && !(port_hit && is_port(eff_addr))) begin
            case (eff_addr)
                BDM_OFS_PTR0: ptr0_nxt = req.wdata;
                BDM_OFS_PTR1: ptr1_nxt = req.wdata;
                BDM_OFS_BANK: begin
                    dbank_nxt = req.wdata[2:0] & bank_mask(VARIANT);
                    if (VARIANT == BDM_VAR_BANK8) begin
                        pbank_nxt = req.wdata[BDM_PB_BIT];
                    end
                end
                default: ;
            endcase
        end
        if (req.rd) begin
            case (eff_addr)
                BDM_OFS_PTR0: reg_rdata_nxt = ptr0_r;
                BDM_OFS_PTR1: reg_rdata_nxt = ptr1_r;
                BDM_OFS_BANK: reg_rdata_nxt = bank_select_r;
                default: reg_rdata_nxt = BDM_ZERO;
            endcase
        end
        // Bank select view holds only implemented bits
        bank_select_nxt = BDM_ZERO;
        bank_select_nxt[2:0] = dbank_nxt;
        bank_select_nxt[BDM_PB_BIT] = pbank_nxt;
        prog_base_nxt = pbank_nxt ? BDM_PM_BASE1 : BDM_PM_BASE0;
    end

    // Plain state registers; the answer register is separate below
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ptr0_r <= BDM_ZERO;
            ptr1_r <= BDM_ZERO;
            reg_rdata_r <= BDM_ZERO;
            ram_sel_r <= 1'b0;
            rd_valid_r <= 1'b0;
            pbank_r <= 1'b0;
            prog_base_r <= BDM_PM_BASE0;
        end else begin
            ptr0_r <= ptr0_nxt;
            ptr1_r <= ptr1_nxt;
            reg_rdata_r <= reg_rdata_nxt;
            ram_sel_r <= ram_sel_nxt;
            rd_valid_r <= rd_valid_nxt;
            pbank_r <= pbank_nxt;
            prog_base_r <= prog_base_nxt;
        end
    end

    //**************************************************************
    // Data bank keeping across resets
    //**************************************************************
    // Bank is cleared by a reset unless the reset came from a watchdog
    // time-out in power-down; the core keeps rstn high for that case and
    // pulses watchdog_pd_reset instead, so no port value enters an async reset.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dbank_r <= '0;
            bank_select_r <= BDM_BANK_RST;
        end else if (watchdog_pd_reset) begin
            dbank_r <= dbank_r;
            bank_select_r <= bank_select_r;
        end else begin
            dbank_r <= dbank_nxt;
            bank_select_r <= bank_select_nxt;
        end
    end

    //**************************************************************
    // Read answer
    //**************************************************************
    // Answer mux feeds a flop so the output stays registered
    logic [7:0] rdata_nxt;
    always_comb begin
        rdata_nxt = ram_sel_r ? ram_rdata : reg_rdata_r;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= BDM_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    //**************************************************************
    // Assertions
    //**************************************************************
    property p_ptr0_write;
        @(posedge ref_clk) disable iff (!rstn)
        (req.wr && req.addr == BDM_OFS_PTR0) |=> (ptr0_r == $past(req.wdata));
    endproperty
    a_ptr0_write: assert property (p_ptr0_write) else $error("pointer zero not written");

    property p_port0_bank0;
        @(posedge ref_clk) disable iff (!rstn)
        (req.addr == BDM_OFS_PORT0) |-> (mem.bank == '0 && mem.addr == ptr0_r);
    endproperty
    a_port0_bank0: assert property (p_port0_bank0) else $error("port zero left bank 0");

    property p_port1_bank;
        @(posedge ref_clk) disable iff (!rstn)
        (req.addr == BDM_OFS_PORT1 && ptr1_r >= BDM_GP_BASE) |-> (mem.bank == dbank_r);
    endproperty
    a_port1_bank: assert property (p_port1_bank) else $error("port one bank wrong");

    property p_direct_bank0;
        @(posedge ref_clk) disable iff (!rstn)
        (!is_port(req.addr)) |-> (mem.bank == '0 && mem.addr == req.addr);
    endproperty
    a_direct_bank0: assert property (p_direct_bank0) else $error("direct access banked");

    property p_self_port_read;
        @(posedge ref_clk) disable iff (!rstn)
        (req.rd && req.addr == BDM_OFS_PORT1 && is_port(ptr1_r)) |=> ##1 (rdata_r == BDM_ZERO);
    endproperty
    a_self_port_read: assert property (p_self_port_read) else $error("port read not zero");

    property p_unused_zero;
        @(posedge ref_clk) disable iff (!rstn)
        (bank_select_r[7:6] == 2'b00) && (bank_select_r[4:3] == 2'b00);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("reserved bits set");

    property p_prog_base;
        @(posedge ref_clk) disable iff (!rstn)
        prog_base_r == (bank_select_r[BDM_PB_BIT] ? BDM_PM_BASE1 : BDM_PM_BASE0);
    endproperty
    a_prog_base: assert property (p_prog_base) else $error("program base mismatch");

    property p_watchdog_keep;
        @(posedge ref_clk) disable iff (!rstn)
        watchdog_pd_reset |=> $stable(dbank_r);
    endproperty
    a_watchdog_keep: assert property (p_watchdog_keep) else $error("bank lost on watchdog");

    property p_bank_write;
        @(posedge ref_clk) disable iff (!rstn)
        (req.wr && req.addr == BDM_OFS_BANK && !watchdog_pd_reset)
            |=> (bank_select_r[2:0] == ($past(req.wdata[2:0]) & bank_mask(VARIANT)));
    endproperty
    a_bank_write: assert property (p_bank_write) else $error("bank write lost");
endmodule

// [bdm_core_model.sv]
// Core datapath model that issues data-memory requests
`timescale 1ns/10ps
module bdm_core_model
    import bdm_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Answer from the addressing block
    input wire logic rd_valid,
    input wire logic [7:0] rdata,
    // Requests
    output bdm_req_t req
);
    // Idle request at time zero
    initial begin
        req = '0;
    end

    // Write: one request cycle, then idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '0;
    endtask

    // Read: flag stands just after the taking edge, data one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        req <= '0;
        #1 v = rd_valid;
        @(posedge ref_clk);
        #1 d = rdata;
    endtask
endmodule

// [banked_data_memory_indirect_addressing_bench.sv]
// Self-checking bench for the banked data memory addressing block
`timescale 1ns/10ps
module banked_data_memory_indirect_addressing_bench;
    import bdm_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic watchdog_pd_reset = 1'b0;
    bdm_req_t req;
    logic rd_valid_r;
    logic [7:0] rdata_r;
    logic [13:0] prog_base_r;
    logic [7:0] bank_select_r;
    int fails = 0;
    int n_compared = 0;

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    bdm_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .watchdog_pd_reset(watchdog_pd_reset),
        .req(req),
        .rd_valid_r(rd_valid_r), .rdata_r(rdata_r), .prog_base_r(prog_base_r),
        .bank_select_r(bank_select_r));
    bdm_core_model i_core (.ref_clk(ref_clk), .rd_valid(rd_valid_r), .rdata(rdata_r),
        .req(req));

    //**************************************************************
    // Compare helpers
    //**************************************************************
    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Read through the core model and judge both flag and data
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        i_core.rd(a, d, v);
        chk({what, " valid"}, 14'h0001, {13'h0000, v});
        chk(what, {6'h00, exp}, {6'h00, d});
    endtask

    task automatic finish_test;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    //**************************************************************
    // Scenarios
    //**************************************************************
    task automatic t_reset;
        chk("bank reset", 14'h0000, {6'h00, bank_select_r});
        chk("prog reset", BDM_PM_BASE0, prog_base_r);
        $display("test reset done");
    endtask

    // All ones written: only the implemented fields may stick
    task automatic t_fields;
        i_core.wr(BDM_OFS_BANK, 8'hFF);
        @(posedge ref_clk);
        #1 chk("bank ones", 14'h0027, {6'h00, bank_select_r});
        chk("prog upper", BDM_PM_BASE1, prog_base_r);
        rdc("bank read", BDM_OFS_BANK, 8'h27);
        i_core.wr(BDM_OFS_BANK, 8'h00);
        @(posedge ref_clk);
        #1 chk("prog lower", BDM_PM_BASE0, prog_base_r);
        $display("test fields done");
    endtask

    // Same offset in banks 0-6 holds its own value; direct lands in bank 0
    task automatic t_banks;
        i_core.wr(BDM_OFS_PTR1, 8'h90);
        rdc("ptr1", BDM_OFS_PTR1, 8'h90);
        for (int b = 0; b < 7; b++) begin
            i_core.wr(BDM_OFS_BANK, 8'(b));
            i_core.wr(BDM_OFS_PORT1, 8'hA0 + 8'(b));
        end
        i_core.wr(8'h90, 8'h55);
        rdc("direct bank6", 8'h90, 8'h55);
        i_core.wr(BDM_OFS_PTR0, 8'h90);
        rdc("port0 bank6", BDM_OFS_PORT0, 8'h55);
        for (int b = 0; b < 7; b++) begin
            i_core.wr(BDM_OFS_BANK, 8'(b));
            rdc("port1 bank", BDM_OFS_PORT1, (b == 0) ? 8'h55 : 8'hA0 + 8'(b));
            rdc("sfr bank", BDM_OFS_BANK, 8'(b));
        end
        $display("test banks done");
    endtask

    // Pointers aimed at the ports themselves
    task automatic t_self;
        i_core.wr(BDM_OFS_PTR1, BDM_OFS_PORT1);
        i_core.wr(BDM_OFS_PORT1, 8'h77);
        rdc("port1 self", BDM_OFS_PORT1, 8'h00);
        rdc("ptr1 kept", BDM_OFS_PTR1, BDM_OFS_PORT1);
        i_core.wr(BDM_OFS_PTR0, BDM_OFS_PORT0);
        i_core.wr(BDM_OFS_PORT0, 8'h66);
        rdc("port0 self", BDM_OFS_PORT0, 8'h00);
        $display("test self done");
    endtask

    // Watchdog reset in power-down keeps the bank; a full reset clears it
    // A bank write while the watchdog reset is high must not disturb the bank
    task automatic t_watchdog;
        i_core.wr(BDM_OFS_BANK, 8'h03);
        @(posedge ref_clk);
        watchdog_pd_reset <= 1'b1;
        i_core.wr(BDM_OFS_BANK, 8'h05);
        @(posedge ref_clk);
        watchdog_pd_reset <= 1'b0;
        @(posedge ref_clk);
        #1 chk("bank watchdog", 14'h0003, {6'h00, bank_select_r});
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        #1 chk("bank rst", 14'h0000, {6'h00, bank_select_r});
        $display("test watchdog done");
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_fields();
        t_banks();
        t_self();
        t_watchdog();
        finish_test();
    end

    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        #40000;
        fails++;
        finish_test();
    end
endmodule
